// File: rtl/npms_pkg.sv
// Package of constants and types for the node power mode sequencer
package npms_pkg;
	// Register indices on the plain register port
	localparam logic [3:0] ADDR_CTRL = 4'h0;
	localparam logic [3:0] ADDR_STATE = 4'h1;
	localparam logic [3:0] ADDR_STATUS = 4'h2;
	localparam logic [3:0] ADDR_MASK = 4'h3;
	localparam logic [3:0] ADDR_WDT = 4'h4;
	localparam logic [3:0] ADDR_ALARM = 4'h5;
	localparam logic [3:0] ADDR_MODPWR = 4'h6;
	localparam logic [3:0] ADDR_WAKESRC = 4'h7;
	// Control register command field
	localparam logic [1:0] CMD_NONE = 2'h0;
	localparam logic [1:0] CMD_SLEEP = 2'h1;
	localparam logic [1:0] CMD_DEEP = 2'h2;
	localparam logic [1:0] CMD_HIBER = 2'h3;
	localparam int CTRL_CMD_LSB = 0;
	localparam int CTRL_FLAGCLR_BIT = 2;
	// Event bit positions, shared by status, mask and wake source
	localparam int EV_SENSOR = 0;
	localparam int EV_ACCEL = 1;
	localparam int EV_WDT = 2;
	localparam int EV_RTC = 3;
	localparam int EV_WIDTH = 4;
	// Watchdog interval codes 0..9: 16 ms doubling up to 8 s
	localparam logic [3:0] WDT_CODE_MAX = 4'h9;
	localparam int WDT_MIN_MS = 16;
	localparam int CLOCK_MHZ = 250;
	localparam longint WDT_MIN_CYCLES = longint'(WDT_MIN_MS) * 1000 * CLOCK_MHZ;
	// Timed wake limits in seconds: 1 s to 31 days
	localparam int ALARM_MIN_S = 1;
	localparam int ALARM_MAX_DAYS = 31;
	localparam logic [21:0] ALARM_MAX_S = 22'(ALARM_MAX_DAYS * 86400);
	localparam int SEC_CYCLES = 1000000 * CLOCK_MHZ;
	// Number of add-on module power switches
	localparam int MOD_COUNT = 4;
	// Reset values
	localparam logic [3:0] WDT_RESET = 4'h0;
	localparam logic [21:0] ALARM_RESET = 22'h000001;
	// Green indicator blink half period
	localparam int BLINK_MS = 250;
	localparam int BLINK_CYCLES = BLINK_MS * 1000 * CLOCK_MHZ;
	// Operating states, one-hot
	typedef enum logic [3:0] {
		ST_ON = 4'b0001,
		ST_SLEEP = 4'b0010,
		ST_DEEP = 4'b0100,
		ST_HIBER = 4'b1000
	} npms_state_type;
endpackage : npms_pkg

// File: rtl/npms_sequencer.sv
// Power mode sequencer for a battery-powered sensor node
`timescale 1ns/100ps
// Functional notes
// - Four states; program runs only in on
// - Sleep wakes on async or watchdog interrupts
// - Watchdog interval from 16 ms to 8 s
// - Sleep and deep sleep keep processor context
// - Deep sleep wakes on async or RTC alarm
// - Timed wake 1 s to 31 days, RTC
// - Hibernate removes processor and module power
// - Only RTC alarm leaves hibernate
// - Leaving hibernate applies full processor reset
// - Hibernate needs enable switch in enabled position
// - Green blinks after first-run switch enable
// - Each module has switch-controlled off state
// - Flag marks restart caused by hibernate wake
module npms_sequencer #(
	parameter longint WDT_BASE_CYCLES = npms_pkg::WDT_MIN_CYCLES,
	parameter int SECOND_CYCLES = npms_pkg::SEC_CYCLES,
	parameter int BLINK_HALF_CYCLES = npms_pkg::BLINK_CYCLES
) (
	input wire logic i_clock,
	input wire logic i_arst_n,
	input wire logic [3:0] i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [31:0] o_rdata,
	input wire logic i_sensor_int,
	input wire logic i_accel_int,
	input wire logic i_rtc_alarm,
	input wire logic i_hiber_switch,
	output logic o_cpu_run,
	output logic o_cpu_power,
	output logic o_cpu_reset,
	output logic [npms_pkg::MOD_COUNT-1:0] o_mod_power,
	output logic o_red_led,
	output logic o_green_led,
	output logic o_irq
);
	// Current operating state
	npms_pkg::npms_state_type state;
	// Event status, mask and last wake source
	logic [npms_pkg::EV_WIDTH-1:0] status, mask, wake_src;
	// Programmed watchdog code and alarm time in seconds
	logic [3:0] wdt_code;
	logic [21:0] alarm_s;
	// Module switch requests from software
	logic [npms_pkg::MOD_COUNT-1:0] mod_req;
	logic hiber_wake; // Set when the restart came from hibernate
	logic armed; // First-run sequence: switch seen enabled
	// Timers
	logic [40:0] wdt_cnt;
	logic [27:0] sec_cnt;
	logic [21:0] alarm_cnt;
	logic [25:0] blink_cnt;
	logic wdt_fire, alarm_fire;
	logic reset_pend; // Processor reset pulse pending on hibernate exit
	// Register port decode
	logic wr_ctrl;
	logic [1:0] cmd;
	logic [npms_pkg::EV_WIDTH-1:0] events;

	// Watchdog interval in cycles: base doubled per code step
	function automatic logic [40:0] wdt_limit(input logic [3:0] code);
		logic [3:0] c;
		c = (code > npms_pkg::WDT_CODE_MAX) ? npms_pkg::WDT_CODE_MAX : code;
		return 41'(WDT_BASE_CYCLES) << c;
	endfunction : wdt_limit

	// Clamp an alarm time into the legal timed-wake range
	function automatic logic [21:0] alarm_clamp(input logic [21:0] v);
		if (v < 22'(npms_pkg::ALARM_MIN_S))
			return 22'(npms_pkg::ALARM_MIN_S);
		else if (v > npms_pkg::ALARM_MAX_S)
			return npms_pkg::ALARM_MAX_S;
		else
			return v;
	endfunction : alarm_clamp

	assign wr_ctrl = i_wr && (i_addr == npms_pkg::ADDR_CTRL);
	assign cmd = i_wdata[npms_pkg::CTRL_CMD_LSB +: 2];

	// Events raised in every state, whether or not it wakes on them; async sources are ignored in hibernate
	always_comb
	begin
		events = '0;
		events[npms_pkg::EV_RTC] = i_rtc_alarm || alarm_fire;
		events[npms_pkg::EV_WDT] = wdt_fire;
		if (state != npms_pkg::ST_HIBER)
		begin
			events[npms_pkg::EV_SENSOR] = i_sensor_int;
			events[npms_pkg::EV_ACCEL] = i_accel_int;
		end
		else
		begin
			events[npms_pkg::EV_WDT] = 1'b0;
		end
	end

	// State sequencing
	always_ff @(posedge i_clock or negedge i_arst_n)
	begin
		if (!i_arst_n)
			state <= npms_pkg::ST_ON;
		else
		begin
			unique case (state)
				npms_pkg::ST_ON:
				begin
					// Wake events here leave the state alone
					if (wr_ctrl && cmd == npms_pkg::CMD_SLEEP)
						state <= npms_pkg::ST_SLEEP;
					else if (wr_ctrl && cmd == npms_pkg::CMD_DEEP)
						state <= npms_pkg::ST_DEEP;
					else if (wr_ctrl && cmd == npms_pkg::CMD_HIBER && i_hiber_switch)
						state <= npms_pkg::ST_HIBER;
				end
				npms_pkg::ST_SLEEP:
					if (events[npms_pkg::EV_SENSOR] || events[npms_pkg::EV_ACCEL]
						|| events[npms_pkg::EV_WDT])
						state <= npms_pkg::ST_ON;
				npms_pkg::ST_DEEP:
					if (events[npms_pkg::EV_SENSOR] || events[npms_pkg::EV_ACCEL]
						|| events[npms_pkg::EV_RTC])
						state <= npms_pkg::ST_ON;
				npms_pkg::ST_HIBER:
					if (events[npms_pkg::EV_RTC])
						state <= npms_pkg::ST_ON;
			endcase
		end
	end

	// Watchdog timer runs only in sleep
	always_ff @(posedge i_clock or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			wdt_cnt <= '0;
			wdt_fire <= 1'b0;
		end
		else if (state == npms_pkg::ST_SLEEP && !wdt_fire)
		begin
			// One pulse when the programmed interval elapses
			if (wdt_cnt + 41'h1 >= wdt_limit(wdt_code))
			begin
				wdt_fire <= 1'b1;
				wdt_cnt <= '0;
			end
			else
				wdt_cnt <= wdt_cnt + 41'h1;
		end
		else
		begin
			wdt_cnt <= '0;
			wdt_fire <= 1'b0;
		end
	end

	// Timed wake counter: seconds tick enable, then second count
	always_ff @(posedge i_clock or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			sec_cnt <= '0;
			alarm_cnt <= '0;
			alarm_fire <= 1'b0;
		end
		else if ((state == npms_pkg::ST_DEEP || state == npms_pkg::ST_HIBER) && !alarm_fire)
		begin
			if (sec_cnt == 28'(SECOND_CYCLES - 1))
			begin
				sec_cnt <= '0;
				if (alarm_cnt + 22'h1 >= alarm_s)
					alarm_fire <= 1'b1;
				alarm_cnt <= alarm_cnt + 22'h1;
			end
			else
				sec_cnt <= sec_cnt + 28'h1;
		end
		else
		begin
			sec_cnt <= '0;
			alarm_cnt <= '0;
			alarm_fire <= 1'b0;
		end
	end

	// Sticky event status; set wins over a write-one clear
	always_ff @(posedge i_clock or negedge i_arst_n)
	begin
		if (!i_arst_n)
			status <= '0;
		else if (i_wr && i_addr == npms_pkg::ADDR_STATUS)
			status <= (status & ~i_wdata[npms_pkg::EV_WIDTH-1:0]) | events;
		else
			status <= status | events;
	end

	// Last wake source, captured on each exit from a low-power state
	always_ff @(posedge i_clock or negedge i_arst_n)
	begin
		if (!i_arst_n)
			wake_src <= '0;
		else if (state == npms_pkg::ST_SLEEP && (events & 4'h7) != '0)
			wake_src <= events & 4'h7;
		else if (state == npms_pkg::ST_DEEP && (events & 4'hb) != '0)
			wake_src <= events & 4'hb;
		else if (state == npms_pkg::ST_HIBER && events[npms_pkg::EV_RTC])
			wake_src <= 4'h8;
	end

	// Hibernate wake flag survives the processor reset; software clears it
	always_ff @(posedge i_clock or negedge i_arst_n)
	begin
		if (!i_arst_n)
			hiber_wake <= 1'b0;
		else if (state == npms_pkg::ST_HIBER && events[npms_pkg::EV_RTC])
			hiber_wake <= 1'b1;
		else if (wr_ctrl && i_wdata[npms_pkg::CTRL_FLAGCLR_BIT])
			hiber_wake <= 1'b0;
	end

	// Software-written configuration
	always_ff @(posedge i_clock or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			mask <= '0;
			wdt_code <= npms_pkg::WDT_RESET;
			alarm_s <= npms_pkg::ALARM_RESET;
			mod_req <= '0;
		end
		else if (i_wr)
		begin
			unique case (i_addr)
				npms_pkg::ADDR_MASK: mask <= i_wdata[npms_pkg::EV_WIDTH-1:0];
				npms_pkg::ADDR_WDT:
					wdt_code <= (i_wdata[3:0] > npms_pkg::WDT_CODE_MAX)
						? npms_pkg::WDT_CODE_MAX : i_wdata[3:0];
				npms_pkg::ADDR_ALARM: alarm_s <= alarm_clamp(i_wdata[21:0]);
				npms_pkg::ADDR_MODPWR: mod_req <= i_wdata[npms_pkg::MOD_COUNT-1:0];
				default: ;
			endcase
		end
	end

	// Processor power, run and reset; hibernate exit forces a full reset
	always_ff @(posedge i_clock or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			o_cpu_run <= 1'b1;
			o_cpu_power <= 1'b1;
			o_cpu_reset <= 1'b0;
			reset_pend <= 1'b0;
			o_mod_power <= '0;
		end
		else
		begin
			reset_pend <= (state == npms_pkg::ST_HIBER) && events[npms_pkg::EV_RTC];
			o_cpu_reset <= reset_pend;
			// Context kept: power stays on in sleep and deep sleep
			o_cpu_run <= (state == npms_pkg::ST_ON) && !reset_pend;
			o_cpu_power <= (state != npms_pkg::ST_HIBER);
			// Modules lose power with the processor regardless of request
			o_mod_power <= (state == npms_pkg::ST_HIBER) ? '0 : mod_req;
		end
	end

	// First-run indicators: red until switch enabled, then green blinks
	always_ff @(posedge i_clock or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			armed <= 1'b0;
			blink_cnt <= '0;
			o_red_led <= 1'b0;
			o_green_led <= 1'b0;
		end
		else
		begin
			if (i_hiber_switch && state == npms_pkg::ST_ON)
				armed <= 1'b1;
			o_red_led <= !armed && state == npms_pkg::ST_ON;
			if (armed && state == npms_pkg::ST_ON)
			begin
				if (blink_cnt == 26'(BLINK_HALF_CYCLES - 1))
				begin
					blink_cnt <= '0;
					o_green_led <= !o_green_led;
				end
				else
					blink_cnt <= blink_cnt + 26'h1;
			end
			else
			begin
				blink_cnt <= '0;
				o_green_led <= 1'b0;
			end
		end
	end

	// Interrupt output: any unmasked status bit
	always_ff @(posedge i_clock or negedge i_arst_n)
	begin
		if (!i_arst_n)
			o_irq <= 1'b0;
		else
			o_irq <= (status & mask) != '0;
	end

	// Read data, valid the cycle after the read strobe; unmapped reads zero
	always_ff @(posedge i_clock or negedge i_arst_n)
	begin
		if (!i_arst_n)
			o_rdata <= '0;
		else if (i_rd)
		begin
			unique case (i_addr)
				npms_pkg::ADDR_CTRL: o_rdata <= {29'h0, hiber_wake, 2'h0};
				npms_pkg::ADDR_STATE: o_rdata <= {26'h0, armed, i_hiber_switch, state};
				npms_pkg::ADDR_STATUS: o_rdata <= {28'h0, status};
				npms_pkg::ADDR_MASK: o_rdata <= {28'h0, mask};
				npms_pkg::ADDR_WDT: o_rdata <= {28'h0, wdt_code};
				npms_pkg::ADDR_ALARM: o_rdata <= {10'h0, alarm_s};
				npms_pkg::ADDR_MODPWR: o_rdata <= {28'h0, mod_req};
				npms_pkg::ADDR_WAKESRC: o_rdata <= {28'h0, wake_src};
				default: o_rdata <= '0;
			endcase
		end
		else
			o_rdata <= '0;
	end
endmodule : npms_sequencer

// File: testbench/npms_seq_asserts.sv
// Port-level assertions for the power mode sequencer
`timescale 1ns/100ps
module npms_seq_asserts (
	input wire logic i_clock,
	input wire logic i_arst_n,
	input wire logic [3:0] i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [31:0] o_rdata,
	input wire logic i_sensor_int,
	input wire logic i_accel_int,
	input wire logic i_rtc_alarm,
	input wire logic i_hiber_switch,
	input wire logic o_cpu_run,
	input wire logic o_cpu_power,
	input wire logic o_cpu_reset,
	input wire logic [npms_pkg::MOD_COUNT-1:0] o_mod_power,
	input wire logic o_red_led,
	input wire logic o_green_led,
	input wire logic o_irq
);
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (!i_arst_n);
	// Control write while running; commands are only honoured in the on state
	logic go;
	assign go = i_wr && i_addr == npms_pkg::ADDR_CTRL && o_cpu_run;
	a_run_powered: assert property (o_cpu_run |-> o_cpu_power)
		else $error("cpu runs unpowered");
	a_hiber_unpowered: assert property (!o_cpu_power |-> o_mod_power == '0 && !o_cpu_run)
		else $error("modules powered in hibernate");
	a_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 32'h0)
		else $error("read data outside its slot");
	a_low_cmd_halts: assert property (go && i_wdata[1] != i_wdata[0] |->
		##2 !o_cpu_run && o_cpu_power)
		else $error("sleep command did not halt");
	a_hiber_cmd_cuts: assert property (go && i_wdata[1:0] == npms_pkg::CMD_HIBER
		&& i_hiber_switch |-> ##2 !o_cpu_power)
		else $error("hibernate did not cut power");
	a_hiber_needs_switch: assert property (go && i_wdata[1:0] == npms_pkg::CMD_HIBER
		&& !i_hiber_switch |-> ##2 o_cpu_power)
		else $error("hibernate entered with switch off");
	// Reset pulse window excluded: run stays low there on purpose
	a_async_wakes: assert property (!o_cpu_run && o_cpu_power && !o_cpu_reset
		&& (i_sensor_int || i_accel_int) |-> ##2 o_cpu_run)
		else $error("async event did not wake");
	a_rtc_restarts: assert property (!o_cpu_power && i_rtc_alarm |-> ##[1:4] o_cpu_reset)
		else $error("alarm did not restart");
	a_reset_single: assert property (o_cpu_reset |-> o_cpu_power && !o_cpu_run
		##1 !o_cpu_reset)
		else $error("bad processor reset pulse");
	a_red_clears: assert property (o_red_led && i_hiber_switch |-> ##[1:4] !o_red_led)
		else $error("red indicator stuck");
	// Main scenarios reached
	c_hiber: cover property ($fell(o_cpu_power));
	c_green: cover property ($rose(o_green_led));
	c_reset: cover property (o_cpu_reset);
	c_irq: cover property ($rose(o_irq));
endmodule : npms_seq_asserts
bind npms_sequencer npms_seq_asserts npms_seq_asserts_i (.i_clock(i_clock),
	.i_arst_n(i_arst_n), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
	.o_rdata(o_rdata), .i_sensor_int(i_sensor_int), .i_accel_int(i_accel_int),
	.i_rtc_alarm(i_rtc_alarm), .i_hiber_switch(i_hiber_switch), .o_cpu_run(o_cpu_run),
	.o_cpu_power(o_cpu_power), .o_cpu_reset(o_cpu_reset), .o_mod_power(o_mod_power),
	.o_red_led(o_red_led), .o_green_led(o_green_led), .o_irq(o_irq));

// File: testbench/npms_far_model.sv
// Model of the sensor, accelerometer and external alarm sources
`timescale 1ns/100ps
module npms_far_model (
	input wire logic i_clock,
	input wire logic i_arst_n,
	input wire logic [2:0] i_fire,
	output logic o_sensor_int,
	output logic o_accel_int,
	output logic o_rtc_alarm
);
	// Two-stage delay: events arrive late, as real sources do
	logic [2:0] dly;
	always_ff @(posedge i_clock or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			dly <= 3'h0;
			{o_rtc_alarm, o_accel_int, o_sensor_int} <= 3'h0;
		end
		else
		begin
			dly <= i_fire;
			// Outputs copy i_fire two cycles late, so pulses last as long as i_fire; the alarm only fires when commanded
			{o_rtc_alarm, o_accel_int, o_sensor_int} <= dly;
		end
	end
endmodule : npms_far_model

// File: testbench/tb_top.sv
// Self-checking bench for the power mode sequencer
`timescale 1ns/100ps
module tb_top;
	logic i_clock, i_arst_n, i_wr, i_rd, i_hiber_switch, s_int, a_int, r_int;
	logic o_cpu_run, o_cpu_power, o_cpu_reset, o_red_led, o_green_led, o_irq;
	logic [3:0] i_addr, o_mod_power;
	logic [31:0] i_wdata, o_rdata;
	logic [2:0] fire;
	int miscompares = 0;
	int checks = 0;
	npms_sequencer #(.WDT_BASE_CYCLES(4), .SECOND_CYCLES(8), .BLINK_HALF_CYCLES(4))
		npms_sequencer_i (.i_clock(i_clock), .i_arst_n(i_arst_n), .i_addr(i_addr),
		.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
		.i_sensor_int(s_int), .i_accel_int(a_int), .i_rtc_alarm(r_int),
		.i_hiber_switch(i_hiber_switch), .o_cpu_run(o_cpu_run), .o_cpu_power(o_cpu_power),
		.o_cpu_reset(o_cpu_reset), .o_mod_power(o_mod_power), .o_red_led(o_red_led),
		.o_green_led(o_green_led), .o_irq(o_irq));
	npms_far_model npms_far_model_i (.i_clock(i_clock), .i_arst_n(i_arst_n), .i_fire(fire),
		.o_sensor_int(s_int), .o_accel_int(a_int), .o_rtc_alarm(r_int));
	initial
	begin
		i_clock = 0;
		forever #2 i_clock = ~i_clock;
	end
	task wrap_up;
		if (miscompares == 0 && checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : wrap_up
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp)
		begin
			miscompares++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge i_clock);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_clock);
		i_wr <= 1'b0;
	endtask : wr
	// Data stand only in the cycle after the strobe
	task rd(input logic [3:0] a, input logic [31:0] exp);
		@(posedge i_clock);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_clock);
		i_rd <= 1'b0;
		#1 chk(o_rdata, exp);
	endtask : rd
	task pulse(input logic [2:0] f);
		@(posedge i_clock);
		fire <= f;
		@(posedge i_clock);
		fire <= 3'h0;
	endtask : pulse
	// Bounded wait: 0 run, 1 green, 2 processor reset
	task wait_for(input int s);
		repeat (200)
		begin
			@(posedge i_clock);
			#1;
			if ((s == 0 && o_cpu_run === 1'b1) || (s == 1 && o_green_led === 1'b1)
				|| (s == 2 && o_cpu_reset === 1'b1))
				return;
		end
		$display("ERROR %0t wait ran out", $time);
		miscompares++;
		wrap_up();
	endtask : wait_for
	// Table: command, source fired, expected wake source
	logic [1:0] cmd_t [3] = '{npms_pkg::CMD_SLEEP, npms_pkg::CMD_DEEP, npms_pkg::CMD_DEEP};
	logic [2:0] src_t [3] = '{3'h2, 3'h1, 3'h0};
	logic [31:0] exp_t [3] = '{32'h2, 32'h1, 32'h8};
	initial
	begin
		{i_arst_n, i_wr, i_rd, i_hiber_switch, i_addr, i_wdata, fire} = '0;
		repeat (4) @(posedge i_clock);
		i_arst_n <= 1'b1;
		rd(npms_pkg::ADDR_STATE, 32'h1);
		rd(npms_pkg::ADDR_ALARM, 32'h1);
		rd(4'h8, 32'h0);
		wr(npms_pkg::ADDR_CTRL, 32'(npms_pkg::CMD_HIBER));
		rd(npms_pkg::ADDR_STATE, 32'h1);
		chk(32'(o_red_led), 32'h1);
		@(posedge i_clock);
		i_hiber_switch <= 1'b1;
		wait_for(1);
		rd(npms_pkg::ADDR_STATE, 32'h31);
		wr(npms_pkg::ADDR_MODPWR, 32'ha);
		rd(npms_pkg::ADDR_MODPWR, 32'ha);
		chk(32'(o_mod_power), 32'ha);
		wr(npms_pkg::ADDR_MASK, 32'hf);
		wr(npms_pkg::ADDR_WDT, 32'hf);
		rd(npms_pkg::ADDR_WDT, 32'h9);
		wr(npms_pkg::ADDR_WDT, 32'h0);
		wr(npms_pkg::ADDR_MODPWR, 32'h0);
		wr(npms_pkg::ADDR_CTRL, 32'(npms_pkg::CMD_SLEEP));
		repeat (2) @(posedge i_clock);
		#1 chk(32'({o_cpu_run, o_cpu_power}), 32'h1);
		chk(32'(o_mod_power), 32'h0);
		// Shortest interval is four sleep cycles, then one to wake, one to run
		repeat (3) @(posedge i_clock);
		#1 chk(32'(o_cpu_run), 32'h0);
		@(posedge i_clock);
		#1 chk(32'(o_cpu_run), 32'h1);
		rd(npms_pkg::ADDR_WAKESRC, 32'h4);
		chk(32'(o_irq), 32'h1);
		wr(npms_pkg::ADDR_STATUS, 32'hf);
		rd(npms_pkg::ADDR_STATUS, 32'h0);
		chk(32'(o_irq), 32'h0);
		// Long watchdog so only the fired source or the timed alarm can wake
		wr(npms_pkg::ADDR_WDT, 32'h9);
		for (int i = 0; i < 3; i++)
		begin
			wr(npms_pkg::ADDR_CTRL, 32'(cmd_t[i]));
			if (src_t[i] != 3'h0)
				pulse(src_t[i]);
			wait_for(0);
			rd(npms_pkg::ADDR_WAKESRC, exp_t[i]);
			wr(npms_pkg::ADDR_STATUS, 32'hf);
		end
		rd(npms_pkg::ADDR_CTRL, 32'h0);
		pulse(3'h1);
		repeat (4) @(posedge i_clock);
		rd(npms_pkg::ADDR_STATE, 32'h31);
		rd(npms_pkg::ADDR_STATUS, 32'h1);
		wr(npms_pkg::ADDR_STATUS, 32'hf);
		wr(npms_pkg::ADDR_ALARM, 32'd100);
		wr(npms_pkg::ADDR_MODPWR, 32'ha);
		wr(npms_pkg::ADDR_CTRL, 32'(npms_pkg::CMD_HIBER));
		pulse(3'h3);
		repeat (4) @(posedge i_clock);
		#1 chk(32'({o_cpu_power, o_mod_power}), 32'h0);
		pulse(3'h4);
		wait_for(2);
		rd(npms_pkg::ADDR_CTRL, 32'h4);
		rd(npms_pkg::ADDR_WAKESRC, 32'h8);
		chk(32'(o_mod_power), 32'ha);
		wr(npms_pkg::ADDR_MASK, 32'h0);
		rd(npms_pkg::ADDR_STATUS, 32'h8);
		chk(32'(o_irq), 32'h0);
		wr(npms_pkg::ADDR_CTRL, 32'h4);
		rd(npms_pkg::ADDR_CTRL, 32'h0);
		rd(npms_pkg::ADDR_ALARM, 32'd100);
		wrap_up();
	end
endmodule : tb_top
